// ===== verilog/sbs_defs.vh
// constants for the synchronous burst sram pin-control block
`ifndef SBS_DEFS_VH
`define SBS_DEFS_VH
`define SBS_ADDR_W 18
`define SBS_DATA_W 36
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_FIFO_DEPTH 8
`define SBS_FIFO_AW 3
`define SBS_LOW_BITS 2
`define SBS_ZERO2 2'h0
`define SBS_ONE2 2'h1
`define SBS_ST_IDLE 2'h0
`define SBS_ST_READ 2'h1
`define SBS_ST_WRITE 2'h2
`define SBS_ST_SNOOZE 2'h3
`endif

// ===== verilog/sbs_fifo.v
// parameterised fifo carrying read data toward the data pins
`timescale 1ns/1ps
module sbs_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire do_push;
  wire do_pop;
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;
  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
  always @* begin
    out_data = mem[rd_ptr_ff];
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop & ~do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // sbs_fifo

// ===== verilog/sbs_burst_ctr.v
// two-bit burst address generator, linear or interleaved
`timescale 1ns/1ps
`include "sbs_defs.vh"
module sbs_burst_ctr (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [1:0] start_bits,
  input wire advance,
  input wire interleave,
  output wire [1:0] low_bits
);
  reg [1:0] start_ff;
  reg [1:0] count_ff;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      start_ff <= `SBS_ZERO2;
      count_ff <= `SBS_ZERO2;
    end else if (load) begin
      start_ff <= start_bits;
      count_ff <= `SBS_ZERO2;
    end else if (advance) begin
      count_ff <= count_ff + `SBS_ONE2; // RULE_12
    end
  end
  // interleaved xors the count; linear adds and wraps mod four
  assign low_bits = interleave ? (start_ff ^ count_ff) : (start_ff + count_ff); // RULE_17 RULE_18
endmodule // sbs_burst_ctr

// ===== verilog/sbs_sram_ctl.v
// pin-level control core of a synchronous pipelined burst sram
`timescale 1ns/1ps
`include "sbs_defs.vh"
// What this block does
// [RULE_01] address pins are captured into a register on the rising clock edge
// [RULE_02] in burst and wait cycles the two low address bits come from the counter
// [RULE_03] each low byte-lane strobe writes its own byte; high means read
// [RULE_04] gate low with any lane strobe low puts the data pins in high impedance
// [RULE_05] lane strobes count only while the sampled byte write gate is low
// [RULE_06] sampled global write low writes the whole 36-bit word
// [RULE_07] address, data, enables, write and burst controls registered every rising edge
// [RULE_08] primary select low enables; while high the processor strobe is ignored
// [RULE_09] device selected only while depth_select_hi is high
// [RULE_10] where present, depth_select_lo must also be low for selection
// [RULE_11] output drivers follow output enable asynchronously
// [RULE_12] advance low steps the burst counter; high is a wait cycle
// [RULE_13] processor strobe with primary select low loads address and starts a read
// [RULE_14] controller strobe loads address and selection, then reads or writes
// [RULE_15] burst order input low gives linear, high gives interleaved
// [RULE_16] snooze high enters low-power standby; low for normal operation
// [RULE_17] linear order adds the advance count to start bits modulo four
// [RULE_18] interleaved order xors start bits with the advance count
module sbs_sram_ctl #(
  parameter ADDR_W = `SBS_ADDR_W,
  parameter DATA_W = `SBS_DATA_W,
  parameter LANES = `SBS_LANES,
  parameter LANE_W = `SBS_LANE_W,
  parameter FIFO_DEPTH = `SBS_FIFO_DEPTH,
  parameter HAS_DEPTH_SELECT_LO = 1
) (
  input wire clk,
  input wire rst,
  input wire [ADDR_W-1:0] addr,
  input wire primary_select_n,
  input wire depth_select_hi,
  input wire depth_select_lo,
  input wire processor_addr_strobe_n,
  input wire controller_addr_strobe_n,
  input wire burst_advance_n,
  input wire byte_lane_a_write_n,
  input wire byte_lane_b_write_n,
  input wire byte_lane_c_write_n,
  input wire byte_lane_d_write_n,
  input wire byte_write_gate_n,
  input wire all_bytes_write_n,
  input wire output_enable_n,
  input wire burst_order_select,
  input wire snooze_request,
  input wire [DATA_W-1:0] dq_in,
  output wire [DATA_W-1:0] dq_out,
  output wire [DATA_W-1:0] dq_oe,
  output wire snooze_active,
  output wire [ADDR_W-1:0] cur_addr,
  output wire selected,
  output wire rd_fifo_ready
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  reg [ADDR_W-1:0] addr_ff;
  reg [DATA_W-1:0] din_ff;
  reg prim_n_ff;
  reg hi_ff;
  reg lo_ff;
  reg ps_n_ff;
  reg cs_n_ff;
  reg adv_n_ff;
  reg [LANES-1:0] lane_n_ff;
  reg gate_n_ff;
  reg gw_n_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [ADDR_W-1:0] base_ff;
  reg [DATA_W-1:0] q_ff;
  reg drive_ff;
  wire [LANES-1:0] lane_n_in;
  wire [LANES-1:0] lane_we;
  wire depth_ok;
  wire start_ps;
  wire start_cs;
  wire load;
  wire is_write;
  wire [1:0] low_bits;
  wire [ADDR_W-1:0] mem_addr;
  wire step;
  wire fifo_out_valid;
  wire [DATA_W-1:0] fifo_out_data;
  wire lane_hiz;
  wire [DATA_W-1:0] rd_word;
  wire [DATA_W-1:0] wr_word;

  assign lane_n_in = {byte_lane_d_write_n, byte_lane_c_write_n, byte_lane_b_write_n, byte_lane_a_write_n};

  // sample every synchronous input on the rising edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_ff <= {ADDR_W{1'b0}};
      din_ff <= {DATA_W{1'b0}};
      prim_n_ff <= 1'b1;
      hi_ff <= 1'b0;
      lo_ff <= 1'b1;
      ps_n_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      adv_n_ff <= 1'b1;
      lane_n_ff <= {LANES{1'b1}};
      gate_n_ff <= 1'b1;
      gw_n_ff <= 1'b1;
    end else begin
      addr_ff <= addr; // RULE_01 RULE_07
      din_ff <= dq_in; // RULE_07
      prim_n_ff <= primary_select_n;
      hi_ff <= depth_select_hi;
      lo_ff <= depth_select_lo;
      ps_n_ff <= processor_addr_strobe_n;
      cs_n_ff <= controller_addr_strobe_n;
      adv_n_ff <= burst_advance_n;
      lane_n_ff <= lane_n_in;
      gate_n_ff <= byte_write_gate_n;
      gw_n_ff <= all_bytes_write_n;
    end
  end

  assign depth_ok = hi_ff & (HAS_DEPTH_SELECT_LO == 0 ? 1'b1 : ~lo_ff); // RULE_09 RULE_10
  // processor strobe is gated by primary select
  assign start_ps = ~ps_n_ff & ~prim_n_ff; // RULE_08 RULE_13
  assign start_cs = ~cs_n_ff; // RULE_14
  assign load = (start_ps | start_cs) & ~snooze_active;
  // a processor-strobe start is always a read, writes come next cycle
  assign is_write = start_cs & ~start_ps & (~gw_n_ff | (~gate_n_ff & ~(&lane_n_ff)));
  // lane enables: global write overrides, else gate qualifies lanes
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      assign lane_we[g] = ~gw_n_ff | (~gate_n_ff & ~lane_n_ff[g]); // RULE_03 RULE_05 RULE_06
      assign wr_word[g*LANE_W +: LANE_W] = lane_we[g] ? din_ff[g*LANE_W +: LANE_W] : rd_word[g*LANE_W +: LANE_W];
    end
  endgenerate

  assign snooze_active = snooze_request; // RULE_16

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `SBS_ST_IDLE, `SBS_ST_READ, `SBS_ST_WRITE: begin
        if (snooze_request) begin
          nxt_state = `SBS_ST_SNOOZE;
        end else if (load) begin
          if (~depth_ok | (start_cs & ~start_ps & prim_n_ff)) begin
            nxt_state = `SBS_ST_IDLE; // RULE_14
          end else if (is_write) begin
            nxt_state = `SBS_ST_WRITE;
          end else begin
            nxt_state = `SBS_ST_READ; // RULE_13
          end
        end else if (state_ff != `SBS_ST_IDLE) begin
          // continuing burst: write controls pick direction per beat
          nxt_state = (~gw_n_ff | (~gate_n_ff & ~(&lane_n_ff))) ? `SBS_ST_WRITE : `SBS_ST_READ;
        end
      end
      `SBS_ST_SNOOZE: begin
        if (~snooze_request) begin
          nxt_state = `SBS_ST_IDLE;
        end
      end
      default: begin
        nxt_state = `SBS_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= `SBS_ST_IDLE;
      base_ff <= {ADDR_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      if (load) begin
        base_ff <= addr_ff; // RULE_01
      end
    end
  end

  // burst beats after the load step when advance was sampled low
  assign step = ~load & ~adv_n_ff & (state_ff != `SBS_ST_IDLE) & (state_ff != `SBS_ST_SNOOZE);

  sbs_burst_ctr u_ctr (
    .clk(clk),
    .rst(rst),
    .load(load),
    .start_bits(addr_ff[1:0]),
    .advance(step),
    .interleave(burst_order_select), // RULE_15
    .low_bits(low_bits)
  );

  assign mem_addr = {base_ff[ADDR_W-1:`SBS_LOW_BITS], low_bits}; // RULE_02
  assign cur_addr = mem_addr;
  assign selected = (state_ff == `SBS_ST_READ) | (state_ff == `SBS_ST_WRITE);

  assign rd_word = mem[mem_addr];

  // one writer for the array: disabled lanes keep their stored bytes
  always @(posedge clk) begin
    if (state_ff == `SBS_ST_WRITE) begin
      mem[mem_addr] <= wr_word; // RULE_03
    end
  end

  // read data passes through the fifo; a full fifo only lowers rd_fifo_ready and does not hold the burst
  sbs_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW(`SBS_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(state_ff == `SBS_ST_READ),
    .in_ready(rd_fifo_ready),
    .in_data(rd_word),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      q_ff <= {DATA_W{1'b0}};
      drive_ff <= 1'b0;
    end else begin
      if (fifo_out_valid) begin
        q_ff <= fifo_out_data;
      end
      drive_ff <= fifo_out_valid | (drive_ff & (state_ff == `SBS_ST_READ));
    end
  end

  // lane strobes low with the gate low turn the pins around at once
  assign lane_hiz = ~byte_write_gate_n & ~(&lane_n_in); // RULE_04
  assign dq_out = q_ff;
  // output enable acts without the clock
  assign dq_oe = {DATA_W{drive_ff & ~output_enable_n & ~lane_hiz & ~snooze_active}}; // RULE_11
endmodule // sbs_sram_ctl

// ===== dv/sbs_sram_ctl_checker.sv
// port-level assertions for the sram control core
`timescale 1ns/1ps
module sbs_sram_ctl_checker #(
  parameter ADDR_W = 18,
  parameter DATA_W = 36
) (
  input wire clk,
  input wire rst,
  input wire primary_select_n,
  input wire depth_select_hi,
  input wire depth_select_lo,
  input wire processor_addr_strobe_n,
  input wire controller_addr_strobe_n,
  input wire burst_advance_n,
  input wire output_enable_n,
  input wire burst_order_select,
  input wire snooze_request,
  input wire [DATA_W-1:0] dq_oe,
  input wire snooze_active,
  input wire [ADDR_W-1:0] cur_addr,
  input wire selected
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire quiet = processor_addr_strobe_n && controller_addr_strobe_n;
  wire ctl_go = !controller_addr_strobe_n && processor_addr_strobe_n && !snooze_request;
  wire sel_ok = !primary_select_n && depth_select_hi && !depth_select_lo;
  // start and select decisions land two edges after sampling
  chk_oe_off: assert property (output_enable_n |-> dq_oe == '0)
    else $error("drivers on while output enable high");
  chk_snooze_echo: assert property (snooze_active == snooze_request)
    else $error("standby flag differs from request");
  chk_snooze_hiz: assert property (snooze_request |-> dq_oe == '0)
    else $error("drivers on in standby");
  chk_proc_start: assert property (!processor_addr_strobe_n && sel_ok && !snooze_request |-> ##[2:3] selected)
    else $error("processor strobe did not select");
  chk_ctl_start: assert property (ctl_go && sel_ok |-> ##[2:3] selected)
    else $error("controller strobe did not select");
  chk_hi_deselect: assert property (ctl_go && !depth_select_hi |-> ##[2:3] !selected)
    else $error("selected with high depth select off");
  chk_lo_deselect: assert property (ctl_go && depth_select_lo |-> ##[2:3] !selected)
    else $error("selected with low depth select off");
  chk_wait_hold: assert property ((selected && burst_advance_n && quiet) [*4] |-> $stable(cur_addr))
    else $error("address moved in wait cycle");
  chk_linear_step: assert property ((selected && !burst_advance_n && quiet && !burst_order_select) [*4]
    |-> cur_addr[1:0] - $past(cur_addr[1:0]) == 2'h1)
    else $error("linear burst step wrong");
  cover property (selected && !burst_advance_n);
  cover property (ctl_go && !sel_ok);
  cover property (snooze_request && selected);
endmodule // sbs_sram_ctl_checker
bind sbs_sram_ctl sbs_sram_ctl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) sbs_sram_ctl_checker_inst (.*);

// ===== dv/sbs_ctl_model.sv
// memory-controller model driving the sram pins
`timescale 1ns/1ps
module sbs_ctl_model (
  input wire logic clk,
  output logic [14:0] pins,
  output logic [17:0] addr,
  output logic [35:0] dq
);
  initial begin
    pins = 15'h0ffa;
    addr = 18'h0;
    dq = 36'h0;
  end
  // changes just after the falling edge, held whole cycles
  task automatic put(input logic [14:0] p, input logic [17:0] a, input logic [35:0] d, input int n);
    @(negedge clk);
    pins = p;
    addr = a;
    dq = d;
    repeat (n - 1) @(negedge clk);
  endtask
endmodule // sbs_ctl_model

// ===== dv/sbs_sram_ctl_tb_top.sv
// self-checking bench for the sram control core
`timescale 1ns/1ps
module sbs_sram_ctl_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [14:0] p;
  logic [17:0] a, cur_addr;
  logic [35:0] d, dq_out, dq_oe, exp;
  logic snooze_active, selected, rd_fifo_ready;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  // expected select in top bit, pin word below
  logic [15:0] rows [7] = '{16'h8ff2, 16'h0ff3, 16'h8fea, 16'h0feb, 16'h0fe8, 16'h0fee, 16'h0ff0};
  initial forever #12.5 clk = ~clk;
  sbs_ctl_model sbs_ctl_model_inst (.clk(clk), .pins(p), .addr(a), .dq(d));
  sbs_sram_ctl sbs_sram_ctl_inst (.clk(clk), .rst(rst), .addr(a), .primary_select_n(p[0]),
    .depth_select_hi(p[1]), .depth_select_lo(p[2]), .processor_addr_strobe_n(p[3]),
    .controller_addr_strobe_n(p[4]), .burst_advance_n(p[5]), .byte_lane_a_write_n(p[6]),
    .byte_lane_b_write_n(p[7]), .byte_lane_c_write_n(p[8]), .byte_lane_d_write_n(p[9]),
    .byte_write_gate_n(p[10]), .all_bytes_write_n(p[11]), .output_enable_n(p[12]),
    .burst_order_select(p[13]), .snooze_request(p[14]), .dq_in(d), .dq_out(dq_out), .dq_oe(dq_oe),
    .snooze_active(snooze_active), .cur_addr(cur_addr), .selected(selected), .rd_fifo_ready(rd_fifo_ready));
  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // strobe cycle, then six cycles holding the controls
  task automatic op(input logic [14:0] q, input logic [17:0] adr, input logic [35:0] dat);
    sbs_ctl_model_inst.put(q, adr, dat, 1);
    sbs_ctl_model_inst.put(q | 15'h0018, adr, dat, 6);
  endtask
  task automatic print_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    check(selected, 36'h0);
    check(cur_addr, 36'h0);
    rst = 1'b0;
    @(negedge clk);
    check(rd_fifo_ready, 36'h1);
    foreach (rows[i]) begin
      op(15'h0fe8, 18'h0, 36'h0);
      op(rows[i][14:0], 18'h2_a5c7, 36'h0);
      check(selected, rows[i][15]);
      if (rows[i][15]) check(cur_addr, 18'h2_a5c7);
    end
    op(15'h07ea, 18'h0_1234, 36'h1_2345_6789);
    op(15'h0fe8, 18'h0, 36'h0);
    op(15'h0aaa, 18'h0_1234, 36'hf_edcb_a987);
    check(dq_oe, 36'h0);
    op(15'h0fe8, 18'h0, 36'h0);
    op(15'h0c2a, 18'h0_1234, 36'h0_5555_aaaa);
    op(15'h0fe8, 18'h0, 36'h0);
    op(15'h0fea, 18'h0_1234, 36'h0);
    exp = (36'hf_edcb_a987 & 36'h0_07fc_01ff) | (36'h1_2345_6789 & ~36'h0_07fc_01ff);
    check(dq_out, exp);
    check(dq_oe, {36{1'b1}});
    // gate and lane a low while drivers are on; pins must turn around before any edge
    sbs_ctl_model_inst.put(15'h0bba, 18'h0, 36'h0, 1);
    #1;
    check(dq_oe, 36'h0);
    sbs_ctl_model_inst.put(15'h1ffa, 18'h0, 36'h0, 1);
    #1;
    check(dq_oe, 36'h0);
    sbs_ctl_model_inst.put(15'h4ffa, 18'h0, 36'h0, 2);
    check(snooze_active, 36'h1);
    check(dq_oe, 36'h0);
    op(15'h0fe8, 18'h0, 36'h0);
    op(15'h0fea, 18'h0_0101, 36'h0);
    // pins show other low bits so the counter must supply them
    sbs_ctl_model_inst.put(15'h0fda, 18'h0_0103, 36'h0, 5);
    sbs_ctl_model_inst.put(15'h0ffa, 18'h0_0103, 36'h0, 5);
    check(cur_addr, 18'h0_0102);
    op(15'h0fe8, 18'h0, 36'h0);
    op(15'h2fea, 18'h0_0101, 36'h0);
    sbs_ctl_model_inst.put(15'h2fda, 18'h0_0103, 36'h0, 3);
    sbs_ctl_model_inst.put(15'h2ffa, 18'h0_0103, 36'h0, 5);
    check(cur_addr, 18'h0_0102);
    print_verdict;
  end
endmodule // sbs_sram_ctl_tb_top
